// File: hdl/ccg_divider.sv
/*
  Event divider: counts source half-period events over a period and
  drives a level high for the first part of it, pulsing on each change.
  Assumes period is at least 2 and high at least 1.
*/
module ccg_divider #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Source events and restart
  ccg_tick_if.snk           in_e,
  input  wire logic         restart,
  // Shape of the output
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] high,
  // Divided events out
  ccg_tick_if.src           out_e
);
  logic [W-1:0] cnt_q;  // Position within period
  logic [W-1:0] cnt_d;  // Next position
  logic         lvl_q;  // Output level
  logic         lvl_d;  // Next output level
  logic         ev_q;   // Output edge pulse

  // Wrap at the end of the period
  always_comb begin
    cnt_d = (cnt_q >= period - 1'b1) ? '0 : cnt_q + 1'b1;
    lvl_d = cnt_d < high;
  end

  // Count on source events; restart truncates the current period
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      lvl_q <= 1'b1;
      ev_q  <= 1'b0;
    end else if (restart) begin
      cnt_q <= '0;
      lvl_q <= 1'b1;
      ev_q  <= !lvl_q;
    end else if (in_e.ev) begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      ev_q  <= lvl_d != lvl_q;
    end else begin
      ev_q  <= 1'b0;
    end
  end

  assign out_e.ev  = ev_q;
  assign out_e.lvl = lvl_q;

  // Period wraps to a high level
  div_wrap_a: assert property (@(posedge clk) disable iff (rst) // RL2
    (in_e.ev && !restart && cnt_q >= period - 1'b1) |=> (cnt_q == '0 && lvl_q))
    else $error("divider did not wrap");
endmodule

// File: hdl/ccg_pin_sense.sv
/*
  Synchronises one clock pin and emits a pulse on each of its edges.
  Assumes the pin toggles slower than half the core clock rate.
*/
module ccg_pin_sense (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw pin level
  input  wire logic pin,
  // Edge events out
  ccg_tick_if.src   tick
);
  logic s1_q;  // First synchroniser stage
  logic s2_q;  // Second synchroniser stage
  logic s3_q;  // Previous settled level
  logic ev_q;  // Edge pulse

  // Two-stage capture, then edge compare on settled stages only
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      ev_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      ev_q <= s2_q ^ s3_q;
    end
  end

  assign tick.ev  = ev_q;
  assign tick.lvl = s3_q;
endmodule

// File: hdl/ccg_pkg.sv
/*
  Shared constants of the codec clock generation block: register
  indices, reset values, write masks, field positions, divider counts.
  Assumes registers sit on a 32-bit APB, one word per register index.
*/
package ccg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] PM1_IDX  = 6'h01;
  localparam logic [5:0] AUX_IDX  = 6'h05;
  localparam logic [5:0] CLK_IDX  = 6'h06;
  localparam logic [5:0] ADD_IDX  = 6'h07;
  localparam logic [5:0] SYNTH_INTEGER_RATIO_IDX = 6'h24;
  localparam logic [5:0] K1_IDX   = 6'h25;
  localparam logic [5:0] K2_IDX   = 6'h26;
  localparam logic [5:0] K3_IDX   = 6'h27;
  localparam logic [5:0] STAT_IDX = 6'h30;
  // Reset values
  localparam logic [8:0] PM1_RST  = 9'h000;
  localparam logic [8:0] AUX_RST  = 9'h000;
  localparam logic [8:0] CLK_RST  = 9'h140;
  localparam logic [8:0] ADD_RST  = 9'h000;
  localparam logic [8:0] SYNTH_INTEGER_RATIO_RST = 9'h04C;
  localparam logic [8:0] K1_RST   = 9'h00C;
  localparam logic [8:0] K2_RST   = 9'h093;
  localparam logic [8:0] K3_RST   = 9'h0E9;
  // Write masks
  localparam logic [8:0] FULL_MASK = 9'h1FF;
  localparam logic [8:0] K1_MASK   = 9'h03F;
  // Field positions
  localparam int SYS_CLOCK_SOURCE_SELECT_BIT  = 8;
  localparam int SYSTEM_CLOCK_DIVIDER_LSB = 5;
  localparam int BIT_CLOCK_DIVIDER_LSB = 2;
  localparam int MS_BIT      = 0;
  localparam int SR_LSB      = 1;
  localparam int SYNTH_ENABLE_BIT   = 5;
  localparam int VMID_LSB    = 0;
  localparam int PD_BIT      = 7;
  localparam int FRACTIONAL_DIVIDE_ENABLE_BIT  = 6;
  localparam int PRESC_LSB   = 4;
  localparam int N_LSB       = 0;
  localparam int ADCLB_BIT   = 0;
  localparam int DACLB_BIT   = 6;
  localparam int GPCLK_BIT   = 8;
  // Divider counts, in half-period events of the source
  localparam logic [9:0] POST_PERIOD  = 10'h008;
  localparam logic [9:0] POST_HIGH    = 10'h004;
  localparam logic [9:0] FRAME_PERIOD = 10'h200;
  localparam logic [9:0] FRAME_HIGH   = 10'h100;
  localparam logic [6:0] BCLK_MAX     = 7'h40;
endpackage

// File: hdl/ccg_tick_if.sv
/*
  Carrier of one derived clock between the block's modules.
  Assumes producer and consumer run on the same core clock.
*/
interface ccg_tick_if;
  logic ev;   // One-cycle pulse per edge of the carried clock
  logic lvl;  // Present level of the carried clock
  modport src (output ev, output lvl);
  modport snk (input ev, input lvl);
endinterface

// File: hdl/ccg_top.sv
/*
  Codec clock generation: selects the system clock source, divides it,
  makes bit and frame clocks as master, holds synthesiser controls and
  routes digital loopback. Registers on APB, one word per index.
  Assumes clock pins toggle slower than half of CORE_CLK.
*/
// Contract
// RL1: Source select picks master clock or synth
// RL2: System divider scales selected clock by code
// RL3: Bit clock divider sets master rates
// RL4: Master bit drives bit/frame clocks out
// RL5: ADC loopback feeds interface output to DAC
// RL6: DAC loopback feeds DAC data to ADC interface
// RL7: Rate code picks filter coefficients
// RL8: Timing scales from a 256fs clock
// RL9: Software picks nearest rate code
// RL10: Synth enable bit turns synthesiser on
// RL11: Zero midrail select keeps synthesiser off
// RL12: Software derives integer and fraction ratios
// RL13: Synth output passes fixed quarter divider
// RL14: Fraction enable gates fractional divide
// RL15: Prescale code conditions synth input
// RL16: Software keeps integer ratio in 6..12
// RL17: Fraction assembled from three registers
// RL18: Synth clock may drive shared pin
// RL19: Frame start may truncate bit clock
// RL20: Software may clear fraction for integers
// RL21: Power-off bit also stops synthesiser
module ccg_top #(
  parameter int DW = 24
) (
  // Clock and reset
  input  wire logic          CORE_CLK,
  input  wire logic          RST,
  // APB slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // Clock inputs
  input  wire logic          MCLK_PIN,
  input  wire logic          SYNTH_CLK_PIN,
  // Bit clock pin
  input  wire logic          BCLK_IN,
  output logic               BCLK_OUT,
  output logic               BCLK_OE_N,
  // Frame clock pin
  input  wire logic          FRAME_IN,
  output logic               FRAME_OUT,
  output logic               FRAME_OE_N,
  // Shared chip select pin
  input  wire logic          CHIP_SELECT_GENERAL_PIN_IN,
  output logic               CHIP_SELECT_GENERAL_PIN_OUT,
  output logic               CHIP_SELECT_GENERAL_PIN_OE_N,
  // Internal clocking
  output logic               INTERNAL_SYSTEM_CLOCK,
  output logic               FS_STROBE,
  output logic      [2:0]    SAMPLE_RATE_CODE,
  // Synthesiser controls
  output logic               SYNTH_ENABLE,
  output logic      [1:0]    SYNTH_INPUT_PRESCALE,
  output logic      [3:0]    SYNTH_INTEGER_RATIO,
  output logic      [23:0]   SYNTH_FRACTION_RATIO,
  output logic               FRACTIONAL_DIVIDE_ENABLE,
  // Loopback data paths
  input  wire logic [DW-1:0] ADC_IFACE_OUT,
  input  wire logic [DW-1:0] DAC_IFACE_OUT,
  input  wire logic [DW-1:0] ADC_PATH_DATA,
  output logic      [DW-1:0] DAC_PATH_DATA,
  output logic      [DW-1:0] ADC_IFACE_IN
);
  // Register storage
  logic [8:0]    pm1_q;      // Power management one
  logic [8:0]    aux_q;      // Loopback and pin control
  logic [8:0]    clk_q;      // Clock generation control
  logic [8:0]    add_q;      // Additional control
  logic [8:0]    synth_integer_ratio_q;     // Synth integer control
  logic [8:0]    k1_q;       // Fraction high
  logic [8:0]    k2_q;       // Fraction mid
  logic [8:0]    k3_q;       // Fraction low
  // Bus state
  logic          pready_q;   // Access answer
  logic          pslverr_q;  // Unmapped access
  logic [31:0]   prdata_q;   // Read data
  logic [31:0]   rd_d;       // Read mux
  logic [5:0]    idx;        // Word index
  logic          hit;        // Mapped, aligned
  logic          wr_done;    // Write completes now
  // Decoded controls
  logic          sys_clock_source_select;     // Source select
  logic          ms;         // Master mode
  logic          synth_on;   // Synth allowed and enabled
  logic          fractional_divide_enable;     // Fractional divide on
  logic [4:0]    sys_per;    // System period, events
  logic [6:0]    bck_per;    // Bit clock period, events
  logic          frm_start;  // Generated frame rising
  logic          bck_rst;    // Bit clock restart
  // Output flops
  logic          internal_system_clock_q;   // System clock level
  logic          bclk_q;     // Bit clock out
  logic          frame_q;    // Frame clock out
  logic          oe_n_q;     // Bit/frame enable
  logic          gp_q;       // Shared pin out
  logic          gp_oe_n_q;  // Shared pin enable
  logic          fs_q;       // Sample strobe
  logic [2:0]    sr_q;       // Rate code out
  logic          syn_en_q;   // Synth enable out
  logic [1:0]    presc_q;    // Prescale out
  logic [3:0]    n_q;        // Integer ratio out
  logic [23:0]   k_q;        // Fraction out
  logic          fen_q;      // Fraction enable out
  logic [DW-1:0] dac_path_q; // DAC data
  logic [DW-1:0] adc_if_q;   // ADC interface data

  // Clock event carriers
  ccg_tick_if mclk_e ();
  ccg_tick_if syn_e ();
  ccg_tick_if bin_e ();
  ccg_tick_if fin_e ();
  ccg_tick_if gin_e ();
  ccg_tick_if post_e ();
  ccg_tick_if sel_e ();
  ccg_tick_if sys_e ();
  ccg_tick_if frm_e ();
  ccg_tick_if bck_e ();

  // Pin synchronisers
  ccg_pin_sense u_mclk (.clk(CORE_CLK), .rst(RST), .pin(MCLK_PIN), .tick(mclk_e));
  ccg_pin_sense u_syn  (.clk(CORE_CLK), .rst(RST), .pin(SYNTH_CLK_PIN), .tick(syn_e));
  ccg_pin_sense u_bin  (.clk(CORE_CLK), .rst(RST), .pin(BCLK_IN), .tick(bin_e));
  ccg_pin_sense u_fin  (.clk(CORE_CLK), .rst(RST), .pin(FRAME_IN), .tick(fin_e));
  ccg_pin_sense u_gin  (.clk(CORE_CLK), .rst(RST), .pin(CHIP_SELECT_GENERAL_PIN_IN),
                        .tick(gin_e));

  // Field decode
  assign sys_clock_source_select   = clk_q[ccg_pkg::SYS_CLOCK_SOURCE_SELECT_BIT];
  assign ms       = clk_q[ccg_pkg::MS_BIT];
  assign fractional_divide_enable   = synth_integer_ratio_q[ccg_pkg::FRACTIONAL_DIVIDE_ENABLE_BIT];
  // Any off condition stops the synthesiser
  assign synth_on = pm1_q[ccg_pkg::SYNTH_ENABLE_BIT]                 // RL10
                    && (pm1_q[ccg_pkg::VMID_LSB +: 2] != 2'h0) // RL11
                    && !synth_integer_ratio_q[ccg_pkg::PD_BIT];               // RL21

  // System divider period, in source half-periods (twice the ratio)
  always_comb begin
    unique case (clk_q[ccg_pkg::SYSTEM_CLOCK_DIVIDER_LSB +: 3]) // RL2
      3'h0: sys_per = 5'h02;
      3'h1: sys_per = 5'h03;
      3'h2: sys_per = 5'h04;
      3'h3: sys_per = 5'h06;
      3'h4: sys_per = 5'h08;
      3'h5: sys_per = 5'h0C;
      3'h6: sys_per = 5'h10;
      3'h7: sys_per = 5'h18;
    endcase
  end

  // Bit clock period; reserved codes behave as the largest ratio
  always_comb begin
    logic [2:0] c;
    c = clk_q[ccg_pkg::BIT_CLOCK_DIVIDER_LSB +: 3];
    if (c > 3'h5) begin
      bck_per = ccg_pkg::BCLK_MAX; // RL3
    end else begin
      bck_per = 7'h02 << c; // RL3
    end
  end

  // Fixed quarter divider on the synthesiser output
  ccg_divider #(.W(10)) u_post (
    .clk     (CORE_CLK),
    .rst     (RST),
    .in_e    (syn_e),
    .restart (!synth_on),
    .period  (ccg_pkg::POST_PERIOD), // RL13
    .high    (ccg_pkg::POST_HIGH),
    .out_e   (post_e)
  );

  // Source choice for the system divider
  assign sel_e.ev  = sys_clock_source_select ? post_e.ev : mclk_e.ev;   // RL1
  assign sel_e.lvl = sys_clock_source_select ? post_e.lvl : mclk_e.lvl; // RL1

  // Programmable system divider
  ccg_divider #(.W(5)) u_sys (
    .clk     (CORE_CLK),
    .rst     (RST),
    .in_e    (sel_e),
    .restart (1'b0),
    .period  (sys_per),
    .high    (sys_per >> 1),
    .out_e   (sys_e)
  );

  // Frame clock: 256 system clock periods per frame
  ccg_divider #(.W(10)) u_frm (
    .clk     (CORE_CLK),
    .rst     (RST),
    .in_e    (sys_e),
    .restart (!ms),
    .period  (ccg_pkg::FRAME_PERIOD), // RL8
    .high    (ccg_pkg::FRAME_HIGH),
    .out_e   (frm_e)
  );

  // Frame start restarts the bit clock, which may cut its last pulse
  assign frm_start = frm_e.ev && frm_e.lvl;
  assign bck_rst   = !ms || frm_start; // RL19

  // Bit clock divider
  ccg_divider #(.W(7)) u_bck (
    .clk     (CORE_CLK),
    .rst     (RST),
    .in_e    (sys_e),
    .restart (bck_rst),
    .period  (bck_per),
    .high    (bck_per >> 1),
    .out_e   (bck_e)
  );

  // Address decode: aligned words at mapped indices only
  assign idx     = PADDR[7:2];
  assign hit     = (PADDR[1:0] == 2'h0) && (idx inside {ccg_pkg::PM1_IDX,
                   ccg_pkg::AUX_IDX, ccg_pkg::CLK_IDX, ccg_pkg::ADD_IDX,
                   ccg_pkg::SYNTH_INTEGER_RATIO_IDX, ccg_pkg::K1_IDX, ccg_pkg::K2_IDX,
                   ccg_pkg::K3_IDX, ccg_pkg::STAT_IDX});
  assign wr_done = PSEL && PENABLE && pready_q && PWRITE && hit;

  // Read mux; status shows live clock levels
  always_comb begin
    rd_d = 32'h0000_0000;
    case (idx)
      ccg_pkg::PM1_IDX:  rd_d[8:0] = pm1_q;
      ccg_pkg::AUX_IDX:  rd_d[8:0] = aux_q;
      ccg_pkg::CLK_IDX:  rd_d[8:0] = clk_q;
      ccg_pkg::ADD_IDX:  rd_d[8:0] = add_q;
      ccg_pkg::SYNTH_INTEGER_RATIO_IDX: rd_d[8:0] = synth_integer_ratio_q;
      ccg_pkg::K1_IDX:   rd_d[8:0] = k1_q;
      ccg_pkg::K2_IDX:   rd_d[8:0] = k2_q;
      ccg_pkg::K3_IDX:   rd_d[8:0] = k3_q;
      ccg_pkg::STAT_IDX: rd_d[5:0] = {sys_e.lvl, gin_e.lvl, fin_e.lvl,
                                      bin_e.lvl, ms, synth_on};
      default:           rd_d = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait state, error on unmapped or unaligned
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (PSEL && PENABLE && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= !hit;
      prdata_q  <= PWRITE ? 32'h0000_0000 : rd_d;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Register writes take effect at the completing edge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pm1_q  <= ccg_pkg::PM1_RST;
      aux_q  <= ccg_pkg::AUX_RST;
      clk_q  <= ccg_pkg::CLK_RST;
      add_q  <= ccg_pkg::ADD_RST;
      synth_integer_ratio_q <= ccg_pkg::SYNTH_INTEGER_RATIO_RST;
      k1_q   <= ccg_pkg::K1_RST;
      k2_q   <= ccg_pkg::K2_RST;
      k3_q   <= ccg_pkg::K3_RST;
    end else if (wr_done) begin
      case (idx)
        ccg_pkg::PM1_IDX:  pm1_q  <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        ccg_pkg::AUX_IDX:  aux_q  <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        ccg_pkg::CLK_IDX:  clk_q  <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        ccg_pkg::ADD_IDX:  add_q  <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        ccg_pkg::SYNTH_INTEGER_RATIO_IDX: synth_integer_ratio_q <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        ccg_pkg::K1_IDX:   k1_q   <= PWDATA[8:0] & ccg_pkg::K1_MASK;
        ccg_pkg::K2_IDX:   k2_q   <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        ccg_pkg::K3_IDX:   k3_q   <= PWDATA[8:0] & ccg_pkg::FULL_MASK;
        default:           pm1_q  <= pm1_q;
      endcase
    end
  end

  // Clock pin drivers; bit and frame pins released while slave, shared pin released while its GPCLK bit is clear
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      internal_system_clock_q  <= 1'b0;
      bclk_q    <= 1'b0;
      frame_q   <= 1'b0;
      oe_n_q    <= 1'b1;
      gp_q      <= 1'b0;
      gp_oe_n_q <= 1'b1;
    end else begin
      internal_system_clock_q  <= sys_e.lvl;
      bclk_q    <= ms && bck_e.lvl; // RL4
      frame_q   <= ms && frm_e.lvl; // RL4
      oe_n_q    <= !ms;             // RL4
      gp_q      <= aux_q[ccg_pkg::GPCLK_BIT] && post_e.lvl;  // RL18
      gp_oe_n_q <= !aux_q[ccg_pkg::GPCLK_BIT];               // RL18
    end
  end

  // Sample strobe from own or received frame, and rate code
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fs_q <= 1'b0;
      sr_q <= 3'h0;
    end else begin
      fs_q <= ms ? frm_start : (fin_e.ev && fin_e.lvl); // RL8
      sr_q <= add_q[ccg_pkg::SR_LSB +: 3];              // RL7
    end
  end

  // Synthesiser control outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      syn_en_q <= 1'b0;
      presc_q  <= 2'h0;
      n_q      <= 4'h0;
      k_q      <= 24'h00_0000;
      fen_q    <= 1'b0;
    end else begin
      syn_en_q <= synth_on;                                 // RL10
      presc_q  <= synth_integer_ratio_q[ccg_pkg::PRESC_LSB +: 2];          // RL15
      n_q      <= synth_integer_ratio_q[ccg_pkg::N_LSB +: 4];
      fen_q    <= fractional_divide_enable;                                   // RL14
      // Fraction reads as zero while fractional divide is off
      k_q      <= fractional_divide_enable ? {k1_q[5:0], k2_q, k3_q} : 24'h00_0000; // RL17
    end
  end

  // Digital loopback routing
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_path_q <= '0;
      adc_if_q   <= '0;
    end else begin
      dac_path_q <= aux_q[ccg_pkg::ADCLB_BIT] ? ADC_IFACE_OUT : DAC_IFACE_OUT; // RL5
      adc_if_q   <= aux_q[ccg_pkg::DACLB_BIT] ? DAC_IFACE_OUT : ADC_PATH_DATA; // RL6
    end
  end

  // Output assignments, all from flops
  assign PRDATA                       = prdata_q;
  assign PREADY                       = pready_q;
  assign PSLVERR                      = pslverr_q;
  assign BCLK_OUT                     = bclk_q;
  assign BCLK_OE_N                    = oe_n_q;
  assign FRAME_OUT                    = frame_q;
  assign FRAME_OE_N                   = oe_n_q;
  assign CHIP_SELECT_GENERAL_PIN_OUT  = gp_q;
  assign CHIP_SELECT_GENERAL_PIN_OE_N = gp_oe_n_q;
  assign INTERNAL_SYSTEM_CLOCK        = internal_system_clock_q;
  assign FS_STROBE                    = fs_q;
  assign SAMPLE_RATE_CODE             = sr_q;
  assign SYNTH_ENABLE                 = syn_en_q;
  assign SYNTH_INPUT_PRESCALE         = presc_q;
  assign SYNTH_INTEGER_RATIO          = n_q;
  assign SYNTH_FRACTION_RATIO         = k_q;
  assign FRACTIONAL_DIVIDE_ENABLE     = fen_q;
  assign DAC_PATH_DATA                = dac_path_q;
  assign ADC_IFACE_IN                 = adc_if_q;

  // Checks on the block's own outputs
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  midrail_gate_a: assert property ( // RL11
    (pm1_q[ccg_pkg::VMID_LSB +: 2] == 2'h0) |=> !SYNTH_ENABLE)
    else $error("synth enabled with midrail select zero");
  synth_on_a: assert property ( // RL10
    (pm1_q[ccg_pkg::SYNTH_ENABLE_BIT] && !synth_integer_ratio_q[ccg_pkg::PD_BIT]
     && pm1_q[ccg_pkg::VMID_LSB +: 2] != 2'h0) |=> SYNTH_ENABLE)
    else $error("synth not enabled");
  fraction_gate_a: assert property ( // RL14
    !fractional_divide_enable |=> (!FRACTIONAL_DIVIDE_ENABLE && SYNTH_FRACTION_RATIO == 24'h00_0000))
    else $error("fraction not gated");
  adc_loop_a: assert property ( // RL5
    aux_q[ccg_pkg::ADCLB_BIT] |=> DAC_PATH_DATA == $past(ADC_IFACE_OUT))
    else $error("adc loopback not routed");
  dac_loop_a: assert property ( // RL6
    aux_q[ccg_pkg::DACLB_BIT] |=> ADC_IFACE_IN == $past(DAC_IFACE_OUT))
    else $error("dac loopback not routed");
  slave_release_a: assert property ( // RL4
    !ms |=> (BCLK_OE_N && FRAME_OE_N && !BCLK_OUT && !FRAME_OUT))
    else $error("clock pins driven as slave");
  rate_write_a: assert property ( // RL7
    (wr_done && idx == ccg_pkg::ADD_IDX)
    |=> ##1 SAMPLE_RATE_CODE == $past(PWDATA[3:1], 2))
    else $error("rate code not taken");
  apb_wait_a: assert property (
    (PSEL && PENABLE && !PREADY) |=> PREADY)
    else $error("apb answer late");
endmodule

// File: verification/ccg_partner.sv
/*
  Far-side model: reference clock, synthesiser output clock and a
  slave-mode audio host. Assumes the bench wires its pins straight in.
*/
module ccg_partner (
  // Device drive of bit and frame pins
  input  wire logic bclk_oe_n,
  input  wire logic bclk_out,
  input  wire logic frame_oe_n,
  input  wire logic frame_out,
  // Levels toward the device
  output logic      mclk,
  output logic      synth_clk,
  output logic      bclk_pin,
  output logic      frame_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       host_bclk;  // Host bit clock
  logic       host_frame; // Host frame clock
  logic [2:0] bit_cnt;    // Bits within half a frame
  // Free-running clocks, all slower than half the core rate
  initial begin
    mclk = 1'b0;
    synth_clk = 1'b0;
    host_bclk = 1'b0;
    host_frame = 1'b0;
    bit_cnt = 3'h0;
    fork
      forever #430 mclk = ~mclk;
      forever #370 synth_clk = ~synth_clk;
      forever #1100 host_bclk = ~host_bclk;
    join
  end
  // Host frame toggles every eight bits
  always @(negedge host_bclk) begin
    bit_cnt <= bit_cnt + 3'h1;
    if (bit_cnt == 3'h7) begin
      host_frame <= ~host_frame;
    end
  end
  // Host lets go of the pins while the device drives them
  assign bclk_pin  = bclk_oe_n ? host_bclk : bclk_out;
  assign frame_pin = frame_oe_n ? host_frame : frame_out;
endmodule

// File: verification/codec_clock_generation_test.sv
/*
  Self-checking bench: register table, synth controls, loopback, dividers.
  Assumes the design files and the far-side model are compiled first.
*/
module codec_clock_generation_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] a;   // Byte address
    logic [8:0] rv;  // Reset value
    logic [8:0] wd;  // Data written
    logic [8:0] ex;  // Data read back
    logic       er;  // Slave error expected
  } ccg_row_t;
  ccg_row_t rows [9] = '{
    '{8'h04, 9'h000, 9'h1FF, 9'h1FF, 1'b0},
    '{8'h14, 9'h000, 9'h1FF, 9'h1FF, 1'b0},
    '{8'h18, 9'h140, 9'h0AA, 9'h0AA, 1'b0},
    '{8'h1C, 9'h000, 9'h00E, 9'h00E, 1'b0},
    '{8'h90, 9'h04C, 9'h1FF, 9'h1FF, 1'b0},
    '{8'h94, 9'h00C, 9'h1FF, 9'h03F, 1'b0},
    '{8'h98, 9'h093, 9'h155, 9'h155, 1'b0},
    '{8'h9C, 9'h0E9, 9'h0AA, 9'h0AA, 1'b0},
    '{8'h08, 9'h000, 9'h1FF, 9'h000, 1'b1}};
  int          r2 [8] = '{2, 3, 4, 6, 8, 12, 16, 24}; // Twice each system ratio
  logic        clk, rst, psel, pen, pwr, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        mclk, synth, bclk, frame, gp, bclk_o, bclk_oe_n, frame_o, frame_oe_n;
  logic        gp_o, gp_oe_n, sys, syn_en, fraction_mode_enable, fs;
  logic [2:0]  rate;
  logic [1:0]  pre;
  logic [3:0]  nint;
  logic [23:0] frac, adc_o, dac_o, adc_p, dac_p, adc_i;
  int          error_cnt, tests_run, cnt [6];
  // Shared pin falls low when nobody drives it
  assign gp = gp_oe_n ? 1'b0 : gp_o;
  ccg_top i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MCLK_PIN(mclk), .SYNTH_CLK_PIN(synth), .BCLK_IN(bclk), .BCLK_OUT(bclk_o),
    .BCLK_OE_N(bclk_oe_n), .FRAME_IN(frame), .FRAME_OUT(frame_o), .FRAME_OE_N(frame_oe_n),
    .CHIP_SELECT_GENERAL_PIN_IN(gp), .CHIP_SELECT_GENERAL_PIN_OUT(gp_o),
    .CHIP_SELECT_GENERAL_PIN_OE_N(gp_oe_n), .INTERNAL_SYSTEM_CLOCK(sys), .FS_STROBE(fs),
    .SAMPLE_RATE_CODE(rate), .SYNTH_ENABLE(syn_en), .SYNTH_INPUT_PRESCALE(pre),
    .SYNTH_INTEGER_RATIO(nint), .SYNTH_FRACTION_RATIO(frac),
    .FRACTIONAL_DIVIDE_ENABLE(fraction_mode_enable), .ADC_IFACE_OUT(adc_o), .DAC_IFACE_OUT(dac_o),
    .ADC_PATH_DATA(adc_p), .DAC_PATH_DATA(dac_p), .ADC_IFACE_IN(adc_i));
  ccg_partner i_far (.bclk_oe_n(bclk_oe_n), .bclk_out(bclk_o), .frame_oe_n(frame_oe_n),
    .frame_out(frame_o), .mclk(mclk), .synth_clk(synth), .bclk_pin(bclk), .frame_pin(frame));
  // Compare and count
  task automatic chk(string n, logic [31:0] g, logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value %s: expected %h, seen %h", n, x, g);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(logic [7:0] a, logic w, logic [8:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {23'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Second edge lets the registered outputs follow the new register
    repeat (2) @(posedge clk);
  endtask
  // Count edges of master, synth, system, bit, shared pin and strobe over a window
  task automatic win();
    logic [5:0] p, c;
    cnt = '{0, 0, 0, 0, 0, 0};
    repeat (50) @(posedge clk);
    p = {fs, gp, bclk_o, sys, synth, mclk};
    repeat (1000) begin
      @(negedge clk);
      c = {fs, gp, bclk_o, sys, synth, mclk};
      for (int k = 0; k < 6; k++) cnt[k] += (c[k] != p[k]);
      p = c;
    end
    @(posedge clk);
  endtask
  function automatic logic near(int a, int b, int t);
    return (a - b <= t) && (b - a <= t);
  endfunction
  // Verdict and end of run
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog against a hang
  initial begin
    #4_000_000;
    error_cnt++;
    test_done();
  end
  // Main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    adc_o = 24'h111111; dac_o = 24'h222222; adc_p = 24'h333333;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pin enables", {bclk_oe_n, frame_oe_n, gp_oe_n}, 3'h7);
    chk("synth fields", {syn_en, fraction_mode_enable, pre, nint}, 8'h4C);
    chk("fraction", frac, 24'h3126E9);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b0, 9'h0);
      chk("reset value", q, rows[i].rv);
      apb(rows[i].a, 1'b1, rows[i].wd);
      chk("slave error", e, rows[i].er);
      apb(rows[i].a, 1'b0, 9'h0);
      chk("read back", q, rows[i].ex);
    end
    chk("synth on", syn_en, 1'b0);
    chk("fraction", frac, {6'h3F, 9'h155, 9'h0AA});
    for (int i = 0; i < 8; i++) begin
      apb(8'h1C, 1'b1, {5'h0, i[2:0], 1'b0});
      chk("rate code", rate, i[2:0]);
    end
    apb(8'h90, 1'b1, 9'h03C);
    chk("synth on", syn_en, 1'b1);
    chk("fraction", frac, 24'h0);
    chk("prescale", {pre, nint}, 6'h3C);
    apb(8'h04, 1'b1, 9'h020);
    chk("synth on", syn_en, 1'b0);
    apb(8'h04, 1'b1, 9'h001);
    chk("synth on", syn_en, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(8'h14, 1'b1, {i[1], 1'b0, i[1], 5'h0, i[0]});
      chk("dac path", dac_p, i[0] ? adc_o : dac_o);
      chk("adc iface", adc_i, i[1] ? dac_o : adc_p);
      chk("shared enable", gp_oe_n, !i[1]);
      chk("shared pin", gp, i[1]);
    end
    foreach (r2[i]) begin
      apb(8'h18, 1'b1, {1'b0, i[2:0], 5'h01});
      win();
      chk("system ratio", near(cnt[2] * r2[i], cnt[0] * 2, 2 * r2[i] + 4), 1'b1);
    end
    chk("pin enables", {bclk_oe_n, frame_oe_n}, 2'h0);
    for (int i = 0; i < 6; i++) begin
      apb(8'h18, 1'b1, {4'h0, i[2:0], 2'h1});
      win();
      chk("bit ratio", near(cnt[3] << i, cnt[2], (2 << i) + 4), 1'b1);
    end
    apb(8'h04, 1'b1, 9'h021);
    apb(8'h90, 1'b1, 9'h04C);
    apb(8'h18, 1'b1, 9'h100);
    win();
    chk("synth source", near(cnt[2] * 4, cnt[1], 12), 1'b1);
    chk("shared clock", near(cnt[4] * 4, cnt[1], 12), 1'b1);
    chk("frame strobes", near(cnt[5], 5, 1), 1'b1);
    apb(8'h18, 1'b1, 9'h101);
    chk("frame level", frame_o, 1'b1);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(8'h18, 1'b0, 9'h0);
    chk("reset value", q, 32'h140);
    apb(8'hC0, 1'b0, 9'h0);
    chk("status", q & 32'h33, 32'h20);
    test_done();
  end
endmodule
